// ==== core/rmt_map.svh ====
// What this block does
// - Advertise capability; initiator ranges only capable neighbours, recipient ignores peer_capable
// - Initiator starts timer, then sends request
// - Request frames use immediate acknowledgement
// - Request carries number of measurement exchanges
// - Measurement sent only after acknowledged request
// - Initiator departure stamp plus transmit calibration
// - Initiator arrival stamp minus receive calibration
// - Report forwarded to management, then timer off
// - Recipient starts timer on received request
// - Recipient arrival stamp minus receive calibration
// - Recipient departure stamp plus transmit calibration
// - Recipient reports after all measurements arrive
// - Recipient may stop timer after report
`ifndef RMT_MAP_SVH
`define RMT_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define RMT_A_CTRL      8'h00
`define RMT_A_COUNT     8'h04
`define RMT_A_TXCAL     8'h08
`define RMT_A_RXCAL     8'h0c
`define RMT_A_STATUS    8'h10
`define RMT_A_INIT_DEP  8'h14
`define RMT_A_INIT_ARR  8'h18
`define RMT_A_RCP_ARR   8'h1c
`define RMT_A_RCP_DEP   8'h20
`define RMT_A_REP_ARR   8'h24
`define RMT_A_REP_DEP   8'h28
`define RMT_A_TIMER     8'h2c

// ==========================================================
// Field positions
`define RMT_CTRL_CAPABLE 0
`define RMT_CTRL_START   1
`define RMT_CTRL_ABORT   2
`define RMT_STAT_DONE    0
`define RMT_STAT_NOCAP   1
`define RMT_STAT_TIMER   2
`define RMT_STAT_STATE   8
`define RMT_STAT_CNT     16

// ==========================================================
// Reset values
`define RMT_COUNT_RST    8'h01
`define RMT_CAL_RST      32'h0000_0000

`endif

// ==== core/rmt_pkg.sv ====
package rmt_pkg;

   // ==========================================================
   // Sequence states
   typedef enum logic [5:0]
   {
      RMT_IDLE     = 6'b000001,
      RMT_I_REQ    = 6'b000010,
      RMT_I_MEAS   = 6'b000100,
      RMT_I_REPORT = 6'b001000,
      RMT_R_MEAS   = 6'b010000,
      RMT_R_REPORT = 6'b100000
   } rmt_state_t;

   // ==========================================================
   // Frame kinds on the MAC side
   typedef enum logic [1:0]
   {
      RMT_K_REQ    = 2'h0,
      RMT_K_MEAS   = 2'h1,
      RMT_K_REPORT = 2'h2,
      RMT_K_ACK    = 2'h3
   } rmt_kind_t;

endpackage

// ==== core/rmt_ranging.sv ====
`timescale 1ns/1ns
`include "rmt_map.svh"

module rmt_ranging
#(
   parameter int TW = 32,
   parameter int CW = 8
)
(
   // Clock, reset, enable
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 pclken,
   // APB slave
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Capability
   input  wire logic                 peer_capable,
   output logic                      capable_advert,
   // Frame transmit request to the MAC
   output logic                      tx_req,
   output rmt_pkg::rmt_kind_t        tx_kind,
   output logic                      tx_imm_ack,
   output logic      [CW-1:0]        tx_count,
   output logic      [TW-1:0]        tx_rep_arr,
   output logic      [TW-1:0]        tx_rep_dep,
   input  wire logic                 tx_mark,
   input  wire logic                 tx_done,
   input  wire logic                 ack_tx_mark,
   // Frame reception from the MAC
   input  wire logic                 rx_mark,
   input  wire rmt_pkg::rmt_kind_t   rx_kind,
   input  wire logic [CW-1:0]        rx_count,
   input  wire logic [TW-1:0]        rx_rep_arr,
   input  wire logic [TW-1:0]        rx_rep_dep,
   // Range timer and management side
   output logic                      timer_on,
   output logic                      dme_report_valid
);
   import rmt_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // State
   rmt_state_t       state;
   rmt_state_t       next_state;
   logic             capable;
   logic [CW-1:0]    meas_total;
   logic [CW-1:0]    meas_cnt;
   logic [TW-1:0]    timer;
   logic [TW-1:0]    tx_cal;
   logic [TW-1:0]    rx_cal;
   logic [TW-1:0]    init_dep;
   logic [TW-1:0]    init_arr;
   logic [TW-1:0]    rcp_arr;
   logic [TW-1:0]    rcp_dep;
   logic [TW-1:0]    rep_arr;
   logic [TW-1:0]    rep_dep;
   logic             done;
   logic             nocap;

   // ==========================================================
   // Bus decode
   wire              setup    = psel & ~penable;
   wire              wr_en    = pclken & psel & penable & pready & pwrite;
   wire              hit_ctrl = paddr == `RMT_A_CTRL;
   wire              hit_cnt  = paddr == `RMT_A_COUNT;
   wire              hit_txc  = paddr == `RMT_A_TXCAL;
   wire              hit_rxc  = paddr == `RMT_A_RXCAL;
   wire              hit_stat = paddr == `RMT_A_STATUS;
   wire              addr_ok  = hit_ctrl | hit_cnt | hit_txc | hit_rxc
                              | hit_stat
                              | (paddr == `RMT_A_INIT_DEP)
                              | (paddr == `RMT_A_INIT_ARR)
                              | (paddr == `RMT_A_RCP_ARR)
                              | (paddr == `RMT_A_RCP_DEP)
                              | (paddr == `RMT_A_REP_ARR)
                              | (paddr == `RMT_A_REP_DEP)
                              | (paddr == `RMT_A_TIMER);
   wire              wr_ctrl  = wr_en & hit_ctrl;
   wire              start_wr = wr_ctrl & pwdata[`RMT_CTRL_START];
   wire              abort_wr = wr_ctrl & pwdata[`RMT_CTRL_ABORT];
   wire              clr_done = wr_en & hit_stat & pwdata[`RMT_STAT_DONE];
   wire              clr_ncap = wr_en & hit_stat & pwdata[`RMT_STAT_NOCAP];

   // ==========================================================
   // Frame events
   wire              ev_tx_mark = pclken & tx_mark;
   wire              ev_tx_done = pclken & tx_done;
   wire              ev_ack_tx  = pclken & ack_tx_mark;
   wire              ev_rx      = pclken & rx_mark;
   wire              ev_rx_req  = ev_rx & (rx_kind == RMT_K_REQ);
   wire              ev_rx_meas = ev_rx & (rx_kind == RMT_K_MEAS);
   wire              ev_rx_rep  = ev_rx & (rx_kind == RMT_K_REPORT);
   wire              ev_rx_ack  = ev_rx & (rx_kind == RMT_K_ACK);
   wire [CW-1:0]     cnt_inc    = meas_cnt + CW'(1);
   wire              last_init  = cnt_inc == meas_total;
   wire              last_rcp   = meas_cnt == meas_total;
   wire              idle       = state == RMT_IDLE;
   wire              start_ok   = start_wr & capable & peer_capable
                                & idle & (meas_total != '0);
   wire              nocap_set  = start_wr & idle
                                & ~(capable & peer_capable);
   wire              rcp_go     = idle & capable & ev_rx_req
                                & (rx_count != '0);
   wire              ack_ok     = ev_rx_ack & ~tx_req;

   // Corrected stamps
   wire [TW-1:0]     stamp_dep  = timer + tx_cal;
   wire [TW-1:0]     stamp_arr  = timer - rx_cal;

   // ==========================================================
   // Next state
   always_comb
   begin
      next_state = state;
      unique case (state)
         RMT_IDLE:
            if (start_ok)
               next_state = RMT_I_REQ;
            else if (rcp_go)
               next_state = RMT_R_MEAS;
         RMT_I_REQ:
            if (ack_ok)
               next_state = RMT_I_MEAS;
         RMT_I_MEAS:
            if (ack_ok & last_init)
               next_state = RMT_I_REPORT;
         RMT_I_REPORT:
            if (ev_rx_rep)
               next_state = RMT_IDLE;
         RMT_R_MEAS:
            if (ev_ack_tx & last_rcp)
               next_state = RMT_R_REPORT;
         RMT_R_REPORT:
            if (ev_tx_done)
               next_state = RMT_IDLE;
         default:
            next_state = RMT_IDLE;
      endcase
      if (abort_wr)
         next_state = RMT_IDLE;
   end

   // Transmit request launch
   wire              go_req  = idle & (next_state == RMT_I_REQ);
   wire              go_meas = (state == RMT_I_REQ & ack_ok)
                             | (state == RMT_I_MEAS & ack_ok & ~last_init);
   wire              go_rep  = state == RMT_R_MEAS
                             & next_state == RMT_R_REPORT;
   wire              launch  = ~abort_wr & (go_req | go_meas | go_rep);
   wire              next_timer_on = (next_state != RMT_IDLE);

   // ==========================================================
   // Sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state      <= RMT_IDLE;
         timer_on   <= 1'b0;
         tx_req     <= 1'b0;
         tx_kind    <= RMT_K_REQ;
         tx_imm_ack <= 1'b0;
         tx_count   <= '0;
      end
      else if (pclken)
      begin
         state    <= next_state;
         timer_on <= next_timer_on;
         if (launch)
         begin
            tx_req     <= 1'b1;
            tx_kind    <= go_req ? RMT_K_REQ :
                          go_meas ? RMT_K_MEAS : RMT_K_REPORT;
            tx_imm_ack <= go_req | go_meas;
            tx_count   <= meas_total;
         end
         else if (tx_done | abort_wr)
            tx_req <= 1'b0;
      end
   end

   // ==========================================================
   // Range timer and measurement count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer    <= '0;
         meas_cnt <= '0;
      end
      else if (pclken)
      begin
         if (timer_on)
            timer <= timer + TW'(1);
         if (idle)
            meas_cnt <= '0;
         else if ((state == RMT_I_MEAS & ack_ok) |
                  (state == RMT_R_MEAS & rx_kind == RMT_K_MEAS & rx_mark))
            meas_cnt <= cnt_inc;
      end
   end

   // ==========================================================
   // Stamps and report
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_dep         <= '0;
         init_arr         <= '0;
         rcp_arr          <= '0;
         rcp_dep          <= '0;
         rep_arr          <= '0;
         rep_dep          <= '0;
         dme_report_valid <= 1'b0;
      end
      else if (pclken)
      begin
         dme_report_valid <= state == RMT_I_REPORT & rx_mark
                           & rx_kind == RMT_K_REPORT;
         if (state == RMT_I_MEAS & tx_mark & tx_kind == RMT_K_MEAS)
            init_dep <= stamp_dep;
         if (state == RMT_I_MEAS & ack_ok)
            init_arr <= stamp_arr;
         if (state == RMT_R_MEAS & ev_rx_meas)
            rcp_arr <= stamp_arr;
         if (state == RMT_R_MEAS & ev_ack_tx)
            rcp_dep <= stamp_dep;
         if (state == RMT_I_REPORT & ev_rx_rep)
         begin
            rep_arr <= rx_rep_arr;
            rep_dep <= rx_rep_dep;
         end
      end
   end

   assign tx_rep_arr = rcp_arr;
   assign tx_rep_dep = rcp_dep;

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         capable        <= 1'b0;
         capable_advert <= 1'b0;
         meas_total     <= CW'(`RMT_COUNT_RST);
         tx_cal         <= TW'(`RMT_CAL_RST);
         rx_cal         <= TW'(`RMT_CAL_RST);
         done           <= 1'b0;
         nocap          <= 1'b0;
      end
      else if (pclken)
      begin
         capable_advert <= capable;
         if (wr_ctrl)
            capable <= pwdata[`RMT_CTRL_CAPABLE];
         if (wr_en & hit_cnt & idle)
            meas_total <= pwdata[CW-1:0];
         else if (rcp_go)
            meas_total <= rx_count;
         if (wr_en & hit_txc)
            tx_cal <= pwdata[TW-1:0];
         if (wr_en & hit_rxc)
            rx_cal <= pwdata[TW-1:0];
         if ((state == RMT_I_REPORT & ev_rx_rep) |
             (state == RMT_R_REPORT & ev_tx_done))
            done <= 1'b1;
         else if (clr_done)
            done <= 1'b0;
         if (nocap_set)
            nocap <= 1'b1;
         else if (clr_ncap)
            nocap <= 1'b0;
      end
   end

   // ==========================================================
   // Read data
   wire [31:0] stat_word = (32'(meas_cnt) << `RMT_STAT_CNT)
                         | (32'(state) << `RMT_STAT_STATE)
                         | (32'(timer_on) << `RMT_STAT_TIMER)
                         | (32'(nocap) << `RMT_STAT_NOCAP)
                         | (32'(done) << `RMT_STAT_DONE);
   wire [31:0] rd_mux =
        hit_ctrl                    ? 32'(capable)
      : hit_cnt                     ? 32'(meas_total)
      : hit_txc                     ? 32'(tx_cal)
      : hit_rxc                     ? 32'(rx_cal)
      : hit_stat                    ? stat_word
      : paddr == `RMT_A_INIT_DEP    ? 32'(init_dep)
      : paddr == `RMT_A_INIT_ARR    ? 32'(init_arr)
      : paddr == `RMT_A_RCP_ARR     ? 32'(rcp_arr)
      : paddr == `RMT_A_RCP_DEP     ? 32'(rcp_dep)
      : paddr == `RMT_A_REP_ARR     ? 32'(rep_arr)
      : paddr == `RMT_A_REP_DEP     ? 32'(rep_dep)
      : paddr == `RMT_A_TIMER       ? 32'(timer)
      : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (pclken)
      begin
         pready  <= setup;
         pslverr <= setup & ~addr_ok;
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Checks
   a_start_capable: assert property (idle && next_state == RMT_I_REQ
      |-> capable && peer_capable) else $error("start without capability");
   a_req_timer_on: assert property (tx_req && tx_kind == RMT_K_REQ
      |-> timer_on) else $error("request sent with timer off");
   a_req_imm_ack: assert property (tx_req && tx_kind != RMT_K_REPORT
      |-> tx_imm_ack) else $error("request or measurement without imm ack");
   a_req_count: assert property (tx_req && tx_kind == RMT_K_REQ
      |-> tx_count == meas_total) else $error("request count mismatch");
   a_meas_after_ack: assert property ($rose(tx_req)
      && tx_kind == RMT_K_MEAS |-> $past(ack_ok))
      else $error("measurement sent without prior ack");
   a_init_dep: assert property (state == RMT_I_MEAS && ev_tx_mark
      && tx_kind == RMT_K_MEAS |=> init_dep == $past(timer) + $past(tx_cal))
      else $error("initiator departure stamp wrong");
   a_init_arr: assert property (state == RMT_I_MEAS && ack_ok
      |=> init_arr == $past(timer) - $past(rx_cal))
      else $error("initiator arrival stamp wrong");
   a_report_fwd: assert property (state == RMT_I_REPORT && ev_rx_rep
      |=> dme_report_valid && rep_arr == $past(rx_rep_arr) && !timer_on)
      else $error("report not forwarded");
   a_rcp_timer: assert property (rcp_go && !start_ok && !abort_wr
      |=> timer_on && state == RMT_R_MEAS)
      else $error("recipient timer not started");
   a_rcp_arr: assert property (state == RMT_R_MEAS && ev_rx_meas
      |=> rcp_arr == $past(timer) - $past(rx_cal))
      else $error("recipient arrival stamp wrong");
   a_rcp_dep: assert property (state == RMT_R_MEAS && ev_ack_tx
      |=> rcp_dep == $past(timer) + $past(tx_cal))
      else $error("recipient departure stamp wrong");
   a_rcp_report: assert property ($rose(tx_req)
      && tx_kind == RMT_K_REPORT |-> meas_cnt == meas_total)
      else $error("report before all measurements");
   a_timer_runs: assert property (pclken && timer_on
      |=> timer == $past(timer) + TW'(1))
      else $error("range timer not counting");

endmodule // rmt_ranging

// ==== bench/rmt_peer.sv ====
`timescale 1ns/1ns
// ==========================================================
// Peer device and MAC frame engine
module rmt_peer
(
   // Clock
   input  wire logic               pclk,
   // Bench commands
   input  wire logic               rcp_go,
   input  wire logic [7:0]         rcp_n,
   input  wire logic [1:0]         gap,
   input  wire logic [31:0]        rep_val,
   // Design transmit side
   input  wire logic               tx_req,
   input  wire rmt_pkg::rmt_kind_t tx_kind,
   input  wire logic [7:0]         tx_count,
   output logic                    tx_mark,
   output logic                    tx_done,
   output logic                    ack_tx_mark,
   // Design receive side
   output logic                    rx_mark,
   output rmt_pkg::rmt_kind_t      rx_kind,
   output logic [7:0]              rx_count,
   output logic [31:0]             rx_rep_arr,
   output logic [31:0]             rx_rep_dep
);
   import rmt_pkg::*;
   int        left = 0;
   rmt_kind_t k;
   // Quiet cycles; unqualified lines keep changing
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         {tx_mark, tx_done, ack_tx_mark, rx_mark} <= 4'h0;
         rx_kind <= rmt_kind_t'(rx_kind + 2'h1);
         rx_count <= ~rx_count;
         rx_rep_arr <= ~rx_rep_arr;
         rx_rep_dep <= ~rx_rep_dep;
      end
   endtask
   task automatic frame_in(input rmt_kind_t kin);
      @(posedge pclk);
      rx_mark <= 1'b1;
      rx_kind <= kin;
      rx_count <= rcp_n;
      rx_rep_arr <= rep_val;
      rx_rep_dep <= rep_val + 32'h10;
   endtask
   initial
   begin
      {tx_mark, tx_done, ack_tx_mark, rx_mark} = 4'h0;
      rx_kind = RMT_K_REQ;
      rx_count = 8'h00;
      rx_rep_arr = 32'h0;
      rx_rep_dep = 32'h0;
      forever
      begin
         idle(1);
         if (rcp_go)
         begin
            frame_in(RMT_K_REQ);
            for (int i = 0; i < rcp_n; i++)
            begin
               idle(2 + gap);
               frame_in(RMT_K_MEAS);
               idle(1 + gap);
               @(posedge pclk);
               ack_tx_mark <= 1'b1;
            end
         end
         else if (tx_req)
         begin
            k = tx_kind;
            if (k == RMT_K_REQ)
               left = tx_count;
            idle(1 + gap);
            @(posedge pclk);
            tx_mark <= 1'b1;
            idle(1 + gap);
            @(posedge pclk);
            tx_done <= 1'b1;
            idle(1);
            if (k != RMT_K_REPORT)
               frame_in(RMT_K_ACK);
            if (k == RMT_K_MEAS)
               left--;
            if (k == RMT_K_MEAS && left == 0)
            begin
               idle(3 + gap);
               frame_in(RMT_K_REPORT);
            end
         end
      end
   end
endmodule // rmt_peer

// ==== bench/rmt_ranging_bench.sv ====
`timescale 1ns/1ns
`include "rmt_map.svh"
// ==========================================================
// Ranging engine bench
module rmt_ranging_bench;
   import rmt_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, peer_capable = 1'b1, rcp_go = 1'b0, txq = 1'b0;
   logic [7:0] paddr = 8'h00, rcp_n = 8'h02, tx_count, rx_count;
   logic [31:0] pwdata = 32'h0, prdata, tx_rep_arr, tx_rep_dep;
   logic [31:0] rx_rep_arr, rx_rep_dep, last_rd, txcal, rxcal;
   logic [31:0] rep_val = 32'h0;
   logic [1:0] gap = 2'h0;
   logic pready, pslverr, capable_advert, tx_req, tx_imm_ack, tx_mark;
   logic tx_done, ack_tx_mark, rx_mark, timer_on, dme_report_valid;
   rmt_kind_t tx_kind, rx_kind;
   logic [33:0] notes[$];
   logic [33:0] note;
   int seed = 32'h0e8f;
   int failures = 0, n_checks = 0, cyc = 0, n_rep = 0, n_acks = 0;
   int n_mtx = 0, n_rm = 0, t_txm = 0, t_ack = 0, t_rm = 0, t_at = 0;

   always #20 pclk = ~pclk;

   rmt_ranging i_rmt_ranging (.pclk(pclk), .presetn(presetn),
      .pclken(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .peer_capable(peer_capable),
      .capable_advert(capable_advert), .tx_req(tx_req), .tx_kind(tx_kind),
      .tx_imm_ack(tx_imm_ack), .tx_count(tx_count),
      .tx_rep_arr(tx_rep_arr), .tx_rep_dep(tx_rep_dep), .tx_mark(tx_mark),
      .tx_done(tx_done), .ack_tx_mark(ack_tx_mark), .rx_mark(rx_mark),
      .rx_kind(rx_kind), .rx_count(rx_count), .rx_rep_arr(rx_rep_arr),
      .rx_rep_dep(rx_rep_dep), .timer_on(timer_on),
      .dme_report_valid(dme_report_valid));
   rmt_peer i_rmt_peer (.pclk(pclk), .rcp_go(rcp_go), .rcp_n(rcp_n),
      .gap(gap), .rep_val(rep_val), .tx_req(tx_req), .tx_kind(tx_kind),
      .tx_count(tx_count), .tx_mark(tx_mark), .tx_done(tx_done),
      .ack_tx_mark(ack_tx_mark), .rx_mark(rx_mark), .rx_kind(rx_kind),
      .rx_count(rx_count), .rx_rep_arr(rx_rep_arr),
      .rx_rep_dep(rx_rep_dep));

   task automatic give_verdict;
      if (failures == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // APB transfer; note is {compare data, error expected, data}
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [33:0] nt);
      int n;
      n = 0;
      @(posedge pclk);
      notes.push_back(nt);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         failures++;
         give_verdict;
      end
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {2'b10, e});
   endtask
   task automatic wait_rep(input int target);
      int n;
      n = 0;
      while (n_rep < target)
      begin
         @(posedge pclk);
         n++;
         if (n > 3000)
         begin
            failures++;
            give_verdict;
         end
      end
   endtask

   // ==========================================================
   // Result watchers
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         note = notes.pop_front();
         last_rd = prdata;
         check("pslverr", 32'(pslverr), 32'(note[32]));
         if (note[33])
            check("prdata", prdata, note[31:0]);
      end
      if (tx_req === 1'b1 && !txq && tx_kind != RMT_K_REPORT)
         check("imm_ack", 32'(tx_imm_ack), 32'h1);
      if (tx_req === 1'b1 && !txq && tx_kind == RMT_K_REQ)
      begin
         check("timer_on at request", 32'(timer_on), 32'h1);
         check("tx_count", 32'(tx_count), 32'h3);
      end
      if (tx_req === 1'b1 && !txq && tx_kind == RMT_K_MEAS)
      begin
         check("acks before meas", n_acks, n_mtx + 1);
         n_mtx++;
      end
      if (tx_req === 1'b1 && !txq && tx_kind == RMT_K_REPORT)
      begin
         check("meas before report", n_rm, 32'(rcp_n));
         check("rcp stamps", tx_rep_dep - tx_rep_arr,
               t_at - t_rm + txcal + rxcal);
      end
      if (tx_done && tx_kind == RMT_K_REPORT)
         n_rep++;
      if (dme_report_valid === 1'b1)
      begin
         check("timer_on at report", 32'(timer_on), 32'h0);
         n_rep++;
      end
      if (ack_tx_mark)
      begin
         check("timer_on at ack", 32'(timer_on), 32'h1);
         t_at = cyc;
      end
      if (tx_mark && tx_kind == RMT_K_MEAS)
         t_txm = cyc;
      if (rx_mark && rx_kind == RMT_K_ACK)
      begin
         n_acks++;
         t_ack = cyc;
      end
      if (rx_mark && rx_kind == RMT_K_MEAS)
      begin
         n_rm++;
         t_rm = cyc;
      end
      txq <= tx_req;
      cyc++;
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      txcal = 32'($random(seed)) & 32'h0000_ffff;
      rxcal = 32'($random(seed)) & 32'h0000_ffff;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`RMT_A_COUNT, 32'h1);
      rd(`RMT_A_TXCAL, 32'h0);
      rd(`RMT_A_STATUS, 32'h100);
      apb(1'b0, 8'h30, 32'h0, {2'b11, 32'h0});
      for (int i = 0; i < 2; i++)
      begin
         peer_capable <= (i == 0);
         wr(`RMT_A_CTRL, 32'(i));
         wr(`RMT_A_CTRL, 32'(i) | 32'h2);
         rd(`RMT_A_STATUS, 32'h102);
         check("timer_on refused", 32'(timer_on), 32'h0);
         check("advert", 32'(capable_advert), 32'(i));
         wr(`RMT_A_STATUS, 32'h2);
      end
      check("advert", 32'(capable_advert), 32'h1);
      gap <= 2'($random(seed));
      rep_val <= 32'($random(seed));
      peer_capable <= 1'b1;
      wr(`RMT_A_TXCAL, txcal);
      wr(`RMT_A_RXCAL, rxcal);
      wr(`RMT_A_COUNT, 32'h3);
      wr(`RMT_A_CTRL, 32'h3);
      wait_rep(1);
      check("meas count", n_mtx, 3);
      rd(`RMT_A_STATUS, 32'h101);
      rd(`RMT_A_REP_ARR, rep_val);
      rd(`RMT_A_REP_DEP, rep_val + 32'h10);
      apb(1'b0, `RMT_A_INIT_DEP, 32'h0, 34'h0);
      @(posedge pclk);
      rd(`RMT_A_INIT_ARR, last_rd + t_ack - t_txm - txcal - rxcal);
      rcp_go <= 1'b1;
      @(posedge pclk);
      rcp_go <= 1'b0;
      wait_rep(2);
      wr(`RMT_A_COUNT, 32'h3);
      wr(`RMT_A_CTRL, 32'h3);
      wr(`RMT_A_CTRL, 32'h5);
      rd(`RMT_A_STATUS, 32'h101);
      give_verdict;
   end
endmodule // rmt_ranging_bench
